// File: logic/awdt_pkg.sv
// types of the auxiliary watchdog
package awdt_pkg;
  typedef enum logic [1:0] {
    AWDT_IDLE = 2'b00,
    AWDT_COUNT = 2'b01,
    AWDT_EXPIRED = 2'b10
  } awdt_mode_t;
  typedef struct packed {
    logic [7:0] units;
    logic [7:0] count_value;
    logic [7:0] cfg;
    logic status;
    logic kbc_en;
  } awdt_regs_t;
  typedef struct packed {
    logic game_access;
    logic kbd_irq;
    logic mouse_irq;
    logic kbc_force_output;
  } awdt_events_t;
  typedef struct packed {
    logic irq1;
    logic irq3;
    logic irq15;
  } awdt_irq_t;
endpackage

// File: logic/awdt_regs.svh
// register offsets, field positions, reset values and timing counts of the auxiliary watchdog
`ifndef AWDT_REGS_SVH
`define AWDT_REGS_SVH
`define AWDT_OFS_UNITS 8'hF1
`define AWDT_OFS_COUNT 8'hF2
`define AWDT_OFS_CFG 8'hF3
`define AWDT_OFS_CTRL 8'hF4
`define AWDT_OFS_IRQ_STAT 8'hF8
`define AWDT_OFS_IRQ_CLR 8'hF9
`define AWDT_OFS_IRQ_EN 8'hFA
`define AWDT_RST_UNITS 8'h00
`define AWDT_RST_COUNT 8'h00
`define AWDT_RST_CFG 8'h00
`define AWDT_RST_CTRL 8'h00
`define AWDT_BIT_UNITS_SEC 7
`define AWDT_BIT_CFG_GAME 0
`define AWDT_BIT_CFG_KBD 1
`define AWDT_BIT_CFG_MOUSE 2
`define AWDT_BIT_CTRL_STAT 0
`define AWDT_BIT_CTRL_FORCE 2
`define AWDT_BIT_CTRL_KBC_EN 3
`define AWDT_CLK_HZ 50000000
`define AWDT_SECOND_S 1
`define AWDT_SECOND_CYC (`AWDT_CLK_HZ * `AWDT_SECOND_S)
`define AWDT_MINUTE_SECONDS 60
`endif

// File: logic/awdt_watchdog.sv
// auxiliary watchdog timer with avalon-mm register slave
//
// Overview of operation
// [RQ1] units bit 7 zero counts minutes, one counts seconds.
// [RQ2] count value zero disables the watchdog.
// [RQ3] nonzero count value is a binary number of 1 to 255 units.
// [RQ4] config bit 0 lets game-port accesses restart the watchdog.
// [RQ5] config bit 1 lets keyboard interrupts restart the watchdog.
// [RQ6] config bit 2 lets mouse interrupts restart the watchdog.
// [RQ7] config bits 7:4 route interrupt: IRQ15, IRQ3, IRQ1, off; 0010 invalid.
// [RQ8] control bit 0 reads one after timeout, zero while counting; writable. Here a force or a restart out of timeout leaves it one while counting.
// [RQ9] writing one to control bit 2 forces a timeout; bit self-clears.
// [RQ10] control bit 3 lets rising edges of keyboard output force timeouts.
// [RQ11] software force still works while keyboard-output forcing is enabled.
// [RQ12] only edges of keyboard output count; detector ORed with software force.
// [RQ13] units, count and config registers reset to zero.
// [RQ14] software writes zeros to reserved control and units bits.
// [RQ15] count decrements per unit, reloads on restart, sets status at zero.
// [RQ16] selected interrupt high while status set and routing enabled.
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
`include "awdt_regs.svh"
module awdt_watchdog #(
  parameter int unsigned SECOND_CYCLES = `AWDT_SECOND_CYC,
  parameter int unsigned MINUTE_SECONDS = `AWDT_MINUTE_SECONDS
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  // avalon-mm slave
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // restart and force sources
  input wire awdt_pkg::awdt_events_t i_events,
  // interrupts
  output awdt_pkg::awdt_irq_t o_irq_lines,
  output logic o_irq
);
  initial begin
    if (SECOND_CYCLES < 2 || MINUTE_SECONDS < 1 || MINUTE_SECONDS > 255) begin
      $error("awdt_watchdog: unsupported timing parameters");
    end
  end

  typedef struct packed {
    awdt_pkg::awdt_regs_t regs;
    awdt_pkg::awdt_mode_t mode;
    logic [31:0] prescale;
    logic [7:0] sec_in_min;
    logic [7:0] remaining;
    logic kbc_prev;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    awdt_pkg::awdt_irq_t lines;
    logic irq;
    logic waitreq;
  } awdt_state_t;

  awdt_state_t st;
  awdt_state_t next_st;
  logic restart;
  logic force_event;
  logic unit_tick;
  logic expire;
  logic wr_hit;
  logic rd_hit;
  logic [7:0] wd;

  always_comb begin
    next_st = st;
    wd = i_writedata[7:0];
    // writes land on the edge where the master sees waitrequest low
    wr_hit = i_write && st.ack;
    rd_hit = i_read && !st.ack;
    // one wait cycle per access: request is answered on the second edge
    next_st.ack = (i_read || i_write) && !st.ack;
    next_st.waitreq = !next_st.ack;
    restart = (i_events.game_access && st.regs.cfg[`AWDT_BIT_CFG_GAME]) // see [RQ4]
      || (i_events.kbd_irq && st.regs.cfg[`AWDT_BIT_CFG_KBD]) // see [RQ5]
      || (i_events.mouse_irq && st.regs.cfg[`AWDT_BIT_CFG_MOUSE]); // see [RQ6]
    next_st.kbc_prev = i_events.kbc_force_output;
    // a level held high for any time yields one event only, see [RQ12]
    force_event = (i_events.kbc_force_output && !st.kbc_prev && st.regs.kbc_en) // see [RQ10]
      || (wr_hit && i_address == `AWDT_OFS_CTRL && wd[`AWDT_BIT_CTRL_FORCE]); // see [RQ9] see [RQ11]

    // prescaler: seconds, then minutes when units bit is clear
    unit_tick = 1'b0;
    if (st.mode != awdt_pkg::AWDT_COUNT || restart) begin
      next_st.prescale = '0;
      next_st.sec_in_min = '0;
    end else if (st.prescale == 32'(SECOND_CYCLES - 1)) begin
      next_st.prescale = '0;
      if (st.regs.units[`AWDT_BIT_UNITS_SEC]) begin // see [RQ1]
        unit_tick = 1'b1;
      end else if (st.sec_in_min == 8'(MINUTE_SECONDS - 1)) begin
        next_st.sec_in_min = '0;
        unit_tick = 1'b1;
      end else begin
        next_st.sec_in_min = st.sec_in_min + 8'h01;
      end
    end else begin
      next_st.prescale = st.prescale + 32'h1;
    end

    expire = 1'b0;
    case (st.mode)
      awdt_pkg::AWDT_IDLE: begin
        if (st.regs.count_value != 8'h00) begin // see [RQ2]
          next_st.mode = awdt_pkg::AWDT_COUNT;
          next_st.remaining = st.regs.count_value; // see [RQ3]
        end
      end
      awdt_pkg::AWDT_COUNT: begin
        if (st.regs.count_value == 8'h00) begin // see [RQ2]
          next_st.mode = awdt_pkg::AWDT_IDLE;
        end else if (restart) begin
          next_st.remaining = st.regs.count_value; // see [RQ15]
        end else if (unit_tick) begin
          if (st.remaining == 8'h01) begin
            expire = 1'b1; // see [RQ15]
            next_st.mode = awdt_pkg::AWDT_EXPIRED;
            next_st.remaining = 8'h00;
          end else begin
            next_st.remaining = st.remaining - 8'h01;
          end
        end
      end
      awdt_pkg::AWDT_EXPIRED: begin
        // counting resumes once software clears status or a restart arrives
        if (!st.regs.status || restart) begin
          next_st.mode = awdt_pkg::AWDT_IDLE;
        end
      end
      default: begin
        next_st.mode = awdt_pkg::AWDT_IDLE;
      end
    endcase

    // register writes
    if (wr_hit) begin
      if (i_address == `AWDT_OFS_UNITS) begin
        next_st.regs.units = wd & 8'h80;
      end else if (i_address == `AWDT_OFS_COUNT) begin
        next_st.regs.count_value = wd;
        if (st.mode == awdt_pkg::AWDT_COUNT) begin
          next_st.remaining = wd;
        end
      end else if (i_address == `AWDT_OFS_CFG) begin
        next_st.regs.cfg = wd & 8'hF7;
      end else if (i_address == `AWDT_OFS_CTRL) begin
        next_st.regs.status = wd[`AWDT_BIT_CTRL_STAT]; // see [RQ8]
        next_st.regs.kbc_en = wd[`AWDT_BIT_CTRL_KBC_EN];
      end else if (i_address == `AWDT_OFS_IRQ_CLR) begin
        next_st.irq_stat = st.irq_stat & ~wd[1:0];
      end else if (i_address == `AWDT_OFS_IRQ_EN) begin
        next_st.irq_en = wd[1:0];
      end
    end
    // hardware set wins over a software clear in the same cycle
    if (expire || force_event) begin
      next_st.regs.status = 1'b1; // see [RQ8]
      next_st.irq_stat[0] = 1'b1;
    end
    if (restart) begin
      next_st.irq_stat[1] = 1'b1;
    end

    // read data, force bit always reads zero since it self-clears
    next_st.rdata = '0;
    if (rd_hit) begin
      if (i_address == `AWDT_OFS_UNITS) begin
        next_st.rdata[7:0] = st.regs.units;
      end else if (i_address == `AWDT_OFS_COUNT) begin
        next_st.rdata[7:0] = st.regs.count_value;
      end else if (i_address == `AWDT_OFS_CFG) begin
        next_st.rdata[7:0] = st.regs.cfg;
      end else if (i_address == `AWDT_OFS_CTRL) begin
        next_st.rdata[7:0] = {4'h0, st.regs.kbc_en, 2'b00, st.regs.status};
      end else if (i_address == `AWDT_OFS_IRQ_STAT) begin
        next_st.rdata[1:0] = st.irq_stat;
      end else if (i_address == `AWDT_OFS_IRQ_EN) begin
        next_st.rdata[1:0] = st.irq_en;
      end
    end

    // routing: invalid code 0010 and all codes other than F, 3 and 1 drive nothing
    next_st.lines = '0;
    if (next_st.regs.status) begin // see [RQ16]
      case (next_st.regs.cfg[7:4]) // see [RQ7]
        4'hF: next_st.lines.irq15 = 1'b1;
        4'h3: next_st.lines.irq3 = 1'b1;
        4'h1: next_st.lines.irq1 = 1'b1;
        default: next_st.lines = '0;
      endcase
    end
    next_st.irq = |(next_st.irq_stat & next_st.irq_en);
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st <= '0;
      st.waitreq <= 1'b1;
      st.regs.units <= `AWDT_RST_UNITS; // see [RQ13]
      st.regs.count_value <= `AWDT_RST_COUNT;
      st.regs.cfg <= `AWDT_RST_CFG;
    end else if (i_clk_en) begin
      st <= next_st;
    end
  end

  assign o_readdata = st.rdata;
  assign o_waitrequest = st.waitreq;
  assign o_irq_lines = st.lines;
  assign o_irq = st.irq;
endmodule
`default_nettype wire

// File: testbench/awdt_chk.sv
// port assertions of the auxiliary watchdog
`timescale 1ns/1ns
`default_nettype none
module awdt_chk (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire awdt_pkg::awdt_events_t i_events,
  input wire awdt_pkg::awdt_irq_t o_irq_lines
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire logic rd_ack = i_read && !o_waitrequest;
  AST_ONE_WAIT: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("answer not after one wait cycle");
  AST_WAIT_BACK: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low too long");
  AST_RD_ZERO: assert property (o_waitrequest |-> o_readdata == 32'h0)
    else $error("readdata not zero outside answer");
  AST_UNMAP: assert property (rd_ack && !(i_address inside {[8'hF1:8'hF4], [8'hF8:8'hFA]}) |-> o_readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_UNITS_RSV: assert property (rd_ack && i_address == 8'hF1 |-> o_readdata[6:0] == 7'h00)
    else $error("units reserved bits set");
  AST_FORCE_RD: assert property (rd_ack && i_address == 8'hF4 |-> !o_readdata[2])
    else $error("force bit not self-cleared");
  AST_ONEHOT: assert property ($onehot0(o_irq_lines))
    else $error("more than one line");
  AST_ROUTE_OFF: assert property (rd_ack && i_address == 8'hF3 && o_readdata[7:4] == 4'h0 |-> o_irq_lines == 3'b000)
    else $error("line high with routing off");
  AST_CLR_LINE: assert property (i_write && !o_waitrequest && i_address == 8'hF4 && i_writedata[2:0] == 3'h0
    && !i_events.kbc_force_output |=> o_irq_lines == 3'b000)
    else $error("line stays after status clear");
endmodule
`default_nettype wire

// File: testbench/awdt_src_model.sv
// far-side sources: game port, keyboard, mouse and keyboard-controller line
`timescale 1ns/1ns
`default_nettype none
module awdt_src_model (
  input wire logic i_clk,
  output var awdt_pkg::awdt_events_t o_events
);
  initial o_events = '0;
  // one high cycle is one restart event; src 0 game, 1 keyboard, 2 mouse
  task automatic kick(input int src);
    o_events[3-src] <= 1'b1;
    @(posedge i_clk);
    o_events[3-src] <= 1'b0;
  endtask
  // caller holds the line high at least 50 cycles (1us)
  task automatic kbc(input logic v);
    o_events.kbc_force_output <= v;
  endtask
endmodule
`default_nettype wire

// File: testbench/awdt_watchdog_test.sv
// self-checking bench of the auxiliary watchdog
`timescale 1ns/1ns
`default_nettype none
bind awdt_watchdog awdt_chk chk (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_address(i_address), .i_read(i_read),
  .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
  .i_events(i_events), .o_irq_lines(o_irq_lines));
module awdt_watchdog_test;
  logic i_clk = 0, i_arst_n = 0, rd = 0, wr = 0, ce = 1, wrq, irq;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rdata, q;
  awdt_pkg::awdt_events_t ev;
  awdt_pkg::awdt_irq_t lines;
  int errors = 0, n_checks = 0;
  logic [3:0] rt [5] = '{4'hF, 4'h3, 4'h1, 4'h2, 4'h0};
  logic [2:0] ex [5] = '{3'b001, 3'b010, 3'b100, 3'b000, 3'b000};
  // short units: one second is 4 clocks, one minute 2 seconds
  awdt_watchdog #(.SECOND_CYCLES(4), .MINUTE_SECONDS(2)) uut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_clk_en(ce),
    .i_address(adr), .i_read(rd), .i_write(wr), .i_writedata(wd), .o_readdata(rdata), .o_waitrequest(wrq),
    .i_events(ev), .o_irq_lines(lines), .o_irq(irq));
  awdt_src_model m (.i_clk(i_clk), .o_events(ev));
  initial forever #10 i_clk = ~i_clk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic till(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // one edge between requests so a strobe is never set twice in one step
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge i_clk);
    end while (wrq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic summarize;
    if (errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    summarize;
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_arst_n <= 1'b1;
    for (int a = 241; a <= 245; a++) rchk(a[7:0], 32'h0);
    bus(1, 8'hF1, 32'hFF);
    rchk(8'hF1, 32'h80);
    bus(1, 8'hF3, 32'hFF);
    rchk(8'hF3, 32'hF7);
    bus(1, 8'hFA, 32'h1);
    bus(1, 8'hF2, 32'h2);
    till(30);
    chk(lines, 3'b001);
    chk(irq, 1'b1);
    rchk(8'hF4, 32'h1);
    bus(1, 8'hFA, 32'h0);
    till(1);
    chk(irq, 1'b0);
    bus(1, 8'hFA, 32'h1);
    till(1);
    chk(irq, 1'b1);
    bus(1, 8'hF9, 32'h1);
    till(1);
    chk(irq, 1'b0);
    for (int i = 0; i < 3; i++) begin
      bus(1, 8'hF3, 32'hF0 | (1 << i));
      bus(1, 8'hF4, 32'h0);
      repeat (12) begin m.kick(i); till(2); end
      chk(lines, 3'b000);
      bus(1, 8'hF3, 32'hF0);
      repeat (12) begin m.kick(i); till(2); end
      chk(lines, 3'b001);
    end
    for (int i = 0; i < 5; i++) begin
      bus(1, 8'hF3, {24'h0, rt[i], 4'h0});
      till(1);
      chk(lines, ex[i]);
    end
    rchk(8'hF3, 32'h0);
    bus(1, 8'hF3, 32'hF0);
    bus(1, 8'hF1, 32'h0);
    bus(1, 8'hF4, 32'h0);
    bus(1, 8'hF2, 32'h2);
    till(10);
    chk(lines, 3'b000);
    till(20);
    chk(lines, 3'b001);
    bus(1, 8'hF2, 32'h0);
    bus(1, 8'hF4, 32'h0);
    till(40);
    rchk(8'hF4, 32'h0);
    // clock enable low must freeze the countdown
    bus(1, 8'hF1, 32'h80);
    bus(1, 8'hF2, 32'h2);
    ce <= 1'b0;
    till(30);
    ce <= 1'b1;
    till(1);
    rchk(8'hF4, 32'h0);
    till(20);
    rchk(8'hF4, 32'h1);
    bus(1, 8'hF2, 32'h0);
    bus(1, 8'hF4, 32'h8);
    m.kbc(1);
    till(50);
    rchk(8'hF4, 32'h9);
    bus(1, 8'hF4, 32'h8);
    till(3);
    rchk(8'hF4, 32'h8);
    m.kbc(0);
    bus(1, 8'hF4, 32'hC);
    rchk(8'hF4, 32'h9);
    bus(1, 8'hF4, 32'h0);
    m.kbc(1);
    till(50);
    rchk(8'hF4, 32'h0);
    m.kbc(0);
    // second reset in mid-run brings the registers back to zero
    i_arst_n <= 1'b0;
    till(2);
    i_arst_n <= 1'b1;
    rchk(8'hF1, 32'h0);
    rchk(8'hF3, 32'h0);
    summarize;
  end
endmodule
`default_nettype wire
